// ---- logic/rtc_month_year_top.sv ----
// Month and year calendar registers behind an AHB-Lite slave
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module rtc_month_year_top
  import rtc_calendar_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timekeeping side
  input wire logic month_carry,
  output logic [7:0] month_value,
  output logic [7:0] year_value,
  output logic leap_year_flag
);

  // Bus handshake: address phase, then one data phase with a wait state
  typedef enum logic {
    BUS_ADDR = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_e;

  calendar_step_if cal ();

  logic carry_pulse;

  // Bus state
  bus_state_e bus_state_reg;
  bus_state_e bus_state_next;
  logic write_reg;
  logic write_next;
  logic [ADDR_DECODE_W-1:0] addr_reg;
  logic [ADDR_DECODE_W-1:0] addr_next;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hresp_reg;
  logic hresp_next;

  // Calendar state
  logic month_tens_reg;
  logic month_tens_next;
  logic [3:0] month_ones_reg;
  logic [3:0] month_ones_next;
  logic [3:0] year_tens_reg;
  logic [3:0] year_tens_next;
  logic [3:0] year_ones_reg;
  logic [3:0] year_ones_next;
  logic leap_reg;
  logic leap_next;

  // Output images
  logic [7:0] month_value_reg;
  logic [7:0] month_value_next;
  logic [7:0] year_value_reg;
  logic [7:0] year_value_next;

  // Decoded access in the data phase
  logic take_request;
  logic month_hit;
  logic year_hit;
  logic month_wr;
  logic year_wr;
  logic month_rd;
  logic year_rd;
  logic [31:0] read_word;
  logic month_tens_wdata;
  logic [3:0] month_ones_wdata;
  logic [3:0] year_tens_wdata;
  logic [3:0] year_ones_wdata;
  logic [7:0] month_read;
  logic [7:0] year_read;

  // Month carry comes from the oscillator domain
  pulse_sync carry_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .level_in(month_carry),
    .rise_pulse(carry_pulse)
  );

  calendar_step step (
    .cal(cal.calc)
  );

  assign cal.month_tens_cur = month_tens_reg;
  assign cal.month_ones_cur = month_ones_reg;
  assign cal.year_tens_cur = year_tens_reg;
  assign cal.year_ones_cur = year_ones_reg;
  assign cal.year_tens_new = year_tens_next;
  assign cal.year_ones_new = year_ones_next;

  // Register read images
  always_comb begin
    month_read = 8'h00;
    month_read[MONTH_LEAP_BIT] = leap_reg;
    month_read[MONTH_TENS_BIT] = month_tens_reg;
    month_read[MONTH_ONES_MSB:MONTH_ONES_LSB] = month_ones_reg;
  end

  always_comb begin
    year_read = 8'h00;
    year_read[YEAR_TENS_MSB:YEAR_TENS_LSB] = year_tens_reg;
    year_read[YEAR_ONES_MSB:YEAR_ONES_LSB] = year_ones_reg;
  end

  // Every NONSEQ transfer gets one wait state so read data can leave a flop
  assign take_request = hsel && hready && (htrans == HTRANS_NONSEQ) && hreadyout_reg;

  // Data-phase decode of the captured address
  always_comb begin
    month_hit = (addr_reg == MONTH_ADDR);
    year_hit = (addr_reg == YEAR_ADDR);
    month_wr = 1'b0;
    year_wr = 1'b0;
    month_rd = 1'b0;
    year_rd = 1'b0;
    if (bus_state_reg == BUS_DATA) begin
      month_wr = write_reg && month_hit;
      year_wr = write_reg && year_hit;
      month_rd = !write_reg && month_hit;
      year_rd = !write_reg && year_hit;
    end
  end

  // Write fields; month bits 7-5 have no writable field and are dropped
  always_comb begin
    month_tens_wdata = hwdata[MONTH_TENS_BIT];
    month_ones_wdata = hwdata[MONTH_ONES_MSB:MONTH_ONES_LSB];
    year_tens_wdata = hwdata[YEAR_TENS_MSB:YEAR_TENS_LSB];
    year_ones_wdata = hwdata[YEAR_ONES_MSB:YEAR_ONES_LSB];
  end

  // Unmapped offsets read as zero
  always_comb begin
    read_word = 32'h00000000;
    if (month_rd) begin
      read_word[7:0] = month_read;
    end else if (year_rd) begin
      read_word[7:0] = year_read;
    end
  end

  // Bus next state
  always_comb begin
    bus_state_next = bus_state_reg;
    write_next = write_reg;
    addr_next = addr_reg;
    hreadyout_next = 1'b1;
    hrdata_next = hrdata_reg;
    hresp_next = HRESP_OKAY;
    unique case (bus_state_reg)
      BUS_ADDR: begin
        if (take_request) begin
          bus_state_next = BUS_DATA;
          write_next = hwrite;
          addr_next = haddr[ADDR_DECODE_W-1:0];
          hreadyout_next = 1'b0;
        end
      end
      BUS_DATA: begin
        bus_state_next = BUS_ADDR;
        if (!write_reg) begin
          hrdata_next = read_word;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= BUS_ADDR;
      write_reg <= 1'b0;
      addr_reg <= '0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
      hresp_reg <= HRESP_OKAY;
    end else begin
      bus_state_reg <= bus_state_next;
      write_reg <= write_next;
      addr_reg <= addr_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
      hresp_reg <= hresp_next;
    end
  end

  // Calendar next state; a software write beats a same-cycle carry
  always_comb begin
    month_tens_next = month_tens_reg;
    month_ones_next = month_ones_reg;
    year_tens_next = year_tens_reg;
    year_ones_next = year_ones_reg;
    if (carry_pulse) begin
      month_tens_next = cal.month_tens_step;
      month_ones_next = cal.month_ones_step;
      year_tens_next = cal.year_tens_step;
      year_ones_next = cal.year_ones_step;
    end
    // A write replaces only its own register, so a carry may still roll the year
    if (month_wr) begin
      month_tens_next = month_tens_wdata;
      month_ones_next = month_ones_wdata;
    end
    if (year_wr) begin
      year_tens_next = year_tens_wdata;
      year_ones_next = year_ones_wdata;
    end
  end

  // Leap flag tracks the year being written, so no read sees it stale
  assign leap_next = cal.leap_new;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      month_tens_reg <= MONTH_TENS_RESET;
      month_ones_reg <= MONTH_ONES_RESET;
      year_tens_reg <= YEAR_TENS_RESET;
      year_ones_reg <= YEAR_ONES_RESET;
      leap_reg <= LEAP_RESET;
    end else begin
      month_tens_reg <= month_tens_next;
      month_ones_reg <= month_ones_next;
      year_tens_reg <= year_tens_next;
      year_ones_reg <= year_ones_next;
      leap_reg <= leap_next;
    end
  end

  // Output images built from next values, so they never lag the registers
  always_comb begin
    month_value_next = 8'h00;
    month_value_next[MONTH_LEAP_BIT] = leap_next;
    month_value_next[MONTH_TENS_BIT] = month_tens_next;
    month_value_next[MONTH_ONES_MSB:MONTH_ONES_LSB] = month_ones_next;
    year_value_next = {year_tens_next, year_ones_next};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      month_value_reg <= {2'b00, LEAP_RESET, MONTH_TENS_RESET, MONTH_ONES_RESET};
      year_value_reg <= {YEAR_TENS_RESET, YEAR_ONES_RESET};
    end else begin
      month_value_reg <= month_value_next;
      year_value_reg <= year_value_next;
    end
  end

  // Outputs
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign month_value = month_value_reg;
  assign year_value = year_value_reg;
  assign leap_year_flag = leap_reg;

endmodule

// ---- inc/rtc_calendar_pkg.sv ----
// Constants and field layout of the month and year calendar registers
//
// Behaviour
// - Month bits 7-6 read zero, writes ignored
// - Month bit 5 is read-only leap-year flag
// - Month bit 4 holds tens digit, 0 or 1
// - Month bits 3-0 hold BCD ones digit
// - Year bits 7-4 hold writable BCD tens
// - Year bits 3-0 hold writable BCD ones
package rtc_calendar_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] MONTH_INDEX = 8'h05;
  localparam logic [7:0] YEAR_INDEX = 8'h06;
  localparam logic [7:0] MONTH_ADDR = {MONTH_INDEX[5:0], 2'b00};
  localparam logic [7:0] YEAR_ADDR = {YEAR_INDEX[5:0], 2'b00};
  localparam int ADDR_DECODE_W = 8;

  // Month register field positions
  localparam int MONTH_LEAP_BIT = 5;
  localparam int MONTH_TENS_BIT = 4;
  localparam int MONTH_ONES_MSB = 3;
  localparam int MONTH_ONES_LSB = 0;

  // Year register field positions
  localparam int YEAR_TENS_MSB = 7;
  localparam int YEAR_TENS_LSB = 4;
  localparam int YEAR_ONES_MSB = 3;
  localparam int YEAR_ONES_LSB = 0;

  // Values after reset
  localparam logic MONTH_TENS_RESET = 1'b0;
  localparam logic [3:0] MONTH_ONES_RESET = 4'h1;
  localparam logic [3:0] YEAR_TENS_RESET = 4'h0;
  localparam logic [3:0] YEAR_ONES_RESET = 4'h1;
  localparam logic LEAP_RESET = 1'b0;

  // BCD limits
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [3:0] MONTH_LAST_ONES = 4'h2;
  localparam logic [3:0] MONTH_FIRST_ONES = 4'h1;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// ---- inc/calendar_step_if.sv ----
// Carrier between the register top and the calendar arithmetic
`timescale 1ns/1ps
interface calendar_step_if;
  logic month_tens_cur;
  logic [3:0] month_ones_cur;
  logic [3:0] year_tens_cur;
  logic [3:0] year_ones_cur;
  logic [3:0] year_tens_new;
  logic [3:0] year_ones_new;
  logic month_tens_step;
  logic [3:0] month_ones_step;
  logic [3:0] year_tens_step;
  logic [3:0] year_ones_step;
  logic leap_new;

  modport calc (
    input month_tens_cur, month_ones_cur, year_tens_cur, year_ones_cur, year_tens_new, year_ones_new,
    output month_tens_step, month_ones_step, year_tens_step, year_ones_step, leap_new
  );
  modport owner (
    output month_tens_cur, month_ones_cur, year_tens_cur, year_ones_cur, year_tens_new, year_ones_new,
    input month_tens_step, month_ones_step, year_tens_step, year_ones_step, leap_new
  );
endinterface

// ---- logic/pulse_sync.sv ----
// Two-stage synchroniser with rising-edge pulse
`timescale 1ns/1ps
module pulse_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, one-cycle pulse out
  input wire logic level_in,
  output logic rise_pulse
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= level_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise_pulse = sync_reg & ~prev_reg;

endmodule

// ---- logic/calendar_step.sv ----
// BCD month and year advance plus leap-year decode
`timescale 1ns/1ps
module calendar_step
  import rtc_calendar_pkg::*;
(
  // Current and next calendar values
  calendar_step_if.calc cal
);

  always_comb begin
    cal.month_tens_step = cal.month_tens_cur;
    cal.month_ones_step = cal.month_ones_cur;
    cal.year_tens_step = cal.year_tens_cur;
    cal.year_ones_step = cal.year_ones_cur;
    if (cal.month_tens_cur && cal.month_ones_cur == MONTH_LAST_ONES) begin
      cal.month_tens_step = 1'b0;
      cal.month_ones_step = MONTH_FIRST_ONES;
      if (cal.year_ones_cur >= BCD_NINE) begin
        cal.year_ones_step = BCD_ZERO;
        cal.year_tens_step = (cal.year_tens_cur >= BCD_NINE) ? BCD_ZERO : 4'(cal.year_tens_cur + 4'h1);
      end else begin
        cal.year_ones_step = 4'(cal.year_ones_cur + 4'h1);
      end
    end else if (cal.month_ones_cur >= BCD_NINE) begin
      cal.month_tens_step = 1'b1;
      cal.month_ones_step = BCD_ZERO;
    end else begin
      cal.month_ones_step = 4'(cal.month_ones_cur + 4'h1);
    end
  end

  // Year mod 4 from BCD: even tens need ones 0/4/8, odd tens need 2/6
  always_comb begin
    if (cal.year_tens_new[0]) begin
      cal.leap_new = (cal.year_ones_new == 4'h2) || (cal.year_ones_new == 4'h6);
    end else begin
      cal.leap_new = (cal.year_ones_new == 4'h0) || (cal.year_ones_new == 4'h4) || (cal.year_ones_new == 4'h8);
    end
  end

endmodule

// ---- verification/rtc_month_year_assertions.sv ----
// Port-level checks of the month and year registers
`timescale 1ns/1ps
module rtc_month_year_chk (
  // Bus and clock
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Calendar image
  input wire logic month_carry,
  input wire logic [7:0] month_value,
  input wire logic [7:0] year_value,
  input wire logic leap_year_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Two-digit year divisible by four, worked on the BCD digits
  wire leap_exp = year_value[4] ? (year_value[3:0] == 4'h2 || year_value[3:0] == 4'h6) :
    (year_value[3:0] == 4'h0 || year_value[3:0] == 4'h4 || year_value[3:0] == 4'h8);
  sequence s_wr(logic [7:0] a);
    hsel && hready && hreadyout && htrans == 2'b10 && hwrite && haddr[7:0] == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    hsel && hready && hreadyout && htrans == 2'b10 && !hwrite && haddr[7:0] == a;
  endsequence
  // Carry seen while the month reads December, and also year 99
  sequence s_dec;
    $rose(month_carry) && month_value[4:0] == 5'h12;
  endsequence
  sequence s_cent;
    $rose(month_carry) && month_value[4:0] == 5'h12 && year_value == 8'h99;
  endsequence
  property p_pad; month_value[7:6] == 2'b00; endproperty
  a_pad: assert property (p_pad) else $error("month pad bits set");
  property p_lpbit; month_value[5] == leap_exp; endproperty
  a_lpbit: assert property (p_lpbit) else $error("month leap bit wrong for year");
  property p_rpad; s_rd(8'h14) |=> ##1 hrdata[31:6] == 26'h0 && hresp == 1'b0; endproperty
  a_rpad: assert property (p_rpad) else $error("month read upper bits set");
  property p_mroll; s_dec |-> ##3 month_value[4:0] == 5'h01; endproperty
  a_mroll: assert property (p_mroll) else $error("month did not wrap to one");
  property p_yroll; s_cent |-> ##3 year_value == 8'h00; endproperty
  a_yroll: assert property (p_yroll) else $error("year did not roll over");
  property p_mten; s_wr(8'h14) |=> ##1 month_value[4] == $past(hwdata[4]); endproperty
  a_mten: assert property (p_mten) else $error("month tens not written");
  property p_mone; s_wr(8'h14) |=> ##1 month_value[3:0] == $past(hwdata[3:0]); endproperty
  a_mone: assert property (p_mone) else $error("month ones not written");
  property p_yten; s_wr(8'h18) |=> ##1 year_value[7:4] == $past(hwdata[7:4]); endproperty
  a_yten: assert property (p_yten) else $error("year tens not written");
  property p_yone; s_wr(8'h18) |=> ##1 year_value[3:0] == $past(hwdata[3:0]); endproperty
  a_yone: assert property (p_yone) else $error("year ones not written");
  property p_leap; leap_year_flag == leap_exp; endproperty
  a_leap: assert property (p_leap) else $error("leap flag wrong for year");
endmodule

// ---- verification/carry_source.sv ----
// Timekeeping model that raises month carries
`timescale 1ns/1ps
module carry_source (
  // Clock and carry level
  input wire logic hclk,
  output logic month_carry
);
  initial month_carry = 1'b0;
  // Each level held three cycles, above the two-cycle minimum
  task automatic pulse();
    repeat (2) begin
      @(posedge hclk);
      month_carry <= ~month_carry;
      repeat (2) @(posedge hclk);
    end
  endtask
endmodule

// ---- verification/rtc_month_year_registers_test.sv ----
// Self-checking bench for the month and year registers
`timescale 1ns/1ps
module rtc_month_year_registers_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, month_carry, leap_year_flag;
  logic [7:0] month_value, year_value;
  logic rd_dp = 1'b0;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int n_tests = 0;
  int t, o;
  always #20 hclk = ~hclk;
  rtc_month_year_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .month_carry(month_carry), .month_value(month_value),
    .year_value(year_value), .leap_year_flag(leap_year_flag));
  carry_source tl (.hclk(hclk), .month_carry(month_carry));
  task test_done();
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error hrdata expected %h seen %h", e, g);
    end
  endtask
  // Bounded wait for hready sampled high
  task wt();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (k >= 40) begin
      num_errors++;
      $display("Error hready expected 1 seen %b", hreadyout);
      test_done();
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt();
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  function logic lp(input int ty, input int oy);
    return (ty * 10 + oy) % 4 == 0;
  endfunction
  // Read completes at the edge where hready returns high
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      rd_dp = 1'b0;
      chk(exp_q.pop_front(), hrdata);
    end
    if (hsel && hreadyout && htrans == 2'b10 && !hwrite) rd_dp = 1'b1;
  end
  initial begin
    void'($urandom(10545));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h14, 32'h01);
    rd(8'h18, 32'h01);
    rd(8'h40, 32'h00);
    bus(1'b1, 8'h14, 32'hf2);
    rd(8'h14, 32'h12);
    for (int i = 0; i < 12; i++) begin
      t = $urandom_range(9);
      o = $urandom_range(9);
      bus(1'b1, 8'h18, {24'h0, t[3:0], o[3:0]});
      rd(8'h18, {24'h0, t[3:0], o[3:0]});
      rd(8'h14, {26'h0, lp(t, o), 5'h12});
    end
    bus(1'b1, 8'h18, 32'h99);
    tl.pulse();
    repeat (6) @(posedge hclk);
    rd(8'h14, 32'h21);
    rd(8'h18, 32'h00);
    bus(1'b1, 8'h14, 32'h09);
    tl.pulse();
    repeat (6) @(posedge hclk);
    rd(8'h14, 32'h30);
    test_done();
  end
endmodule
bind rtc_month_year_top rtc_month_year_chk chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .month_carry(month_carry),
  .month_value(month_value), .year_value(year_value), .leap_year_flag(leap_year_flag));
